// File: core/rsc_pkg.sv
// shared constants and carriers of the reset source controller
package rsc_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 5;          // 200 MHz system clock
   localparam int T_POR_NS      = 300000;     // power-up release delay, 0.3 ms
   localparam int POR_DLY_CYC   = T_POR_NS / CLK_PERIOD_NS;
   localparam int POR_CNT_W     = 17;         // width of the delay counter

   // register map: word index, byte address is four times the index
   localparam int         WB_ADR_W      = 10;
   localparam logic [7:0] REG_CAUSE_IDX = 8'hEF;  // reset cause register
   localparam logic [7:0] REG_SMON_IDX  = 8'hEE;  // supply monitor control

   // cause register bit positions
   localparam int BIT_PIN   = 0;
   localparam int BIT_PWR   = 1;
   localparam int BIT_MCD   = 2;
   localparam int BIT_WDT   = 3;
   localparam int BIT_SW    = 4;
   localparam int BIT_CMP   = 5;
   localparam int BIT_FLASH = 6;

   // supply monitor control bit positions
   localparam int BIT_SMON_EN  = 7;
   localparam int BIT_SMON_SEL = 6;

   // reset values
   localparam logic [7:0]  CAUSE_RST      = 8'h00;
   localparam logic [1:0]  SMON_RST       = 2'h3;   // enabled and selected
   localparam logic [7:0]  PORT_RESET_VAL = 8'hFF;
   localparam logic [15:0] FETCH_START    = 16'h0000;

   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_POR   = 3'b001,
      ST_DELAY = 3'b010,
      ST_HOLD  = 3'b011,
      ST_EXIT  = 3'b100
   } rsc_state_t;

   // controls held toward the core while in reset
   typedef struct packed {
      logic halt;         // stop execution
      logic sfr_init;     // load register reset values
      logic irq_tmr_off;  // interrupts and timers off
      logic sp_init;      // stack pointer only, data memory kept
   } rsc_core_t;

   // one-cycle actions on leaving reset
   typedef struct packed {
      logic        pc_clear;      // program counter to start
      logic        wdt_enable;    // watchdog on
      logic        clk_internal;  // internal oscillator as system clock
      logic [15:0] fetch_addr;    // first fetch address
   } rsc_exit_t;

   // port pin state
   typedef struct packed {
      logic       open_drain;   // latches in open-drain mode
      logic       weak_pullup;  // weak pullups on
      logic [7:0] latch;        // output latch value
   } rsc_port_t;
endpackage

// File: core/rsc_ctrl.sv
// Function
// RL1: any source halts core, inits registers, ports
// RL2: non-power resets keep data memory intact
// RL3: port latches ones, open-drain, pullups on
// RL4: drive pin low only for power resets
// RL5: on exit clear pc, watchdog, internal clock
// RL6: power-up waits supply then release delay
// RL7: power-up sets power flag; others clear it
// RL8: power-up enables and selects supply monitor
// RL9: supply drop drives pin, holds core reset
// RL10: supply reset sets power flag, no delay
// RL11: monitor settings survive all non-power resets
// RL12: flash writes ignored while monitor disabled
// RL13: low pin enters reset, sets pin flag
// RL14: missing clock resets when enabled, flags it
// RL15: clock-loss bit writes enable, reads flag
// RL16: comparator bit enables comparator reset source
// RL17: software lets comparator settle before enabling
// RL18: watchdog expiry resets and sets its flag
// RL19: illegal flash access resets, sets flash flag
// RL20: software bit write forces reset, flags it
// RL21: cause register bit layout, some read-only
// RL22: cause register at index 0xEF
// RL23: release synchronous, all leave together
`timescale 1ns/100ps
module rsc_ctrl #(
   parameter int POR_DELAY_CYC = rsc_pkg::POR_DLY_CYC  // power-up delay
) (
   input  wire logic                        CLK,            // system clock
   input  wire logic                        RST,            // power-up root
   input  wire logic                        WB_CYC_I,       // bus cycle
   input  wire logic                        WB_STB_I,       // bus strobe
   input  wire logic                        WB_WE_I,        // write
   input  wire logic [rsc_pkg::WB_ADR_W-1:0] WB_ADR_I,      // byte address
   input  wire logic [3:0]                  WB_SEL_I,       // byte lanes
   input  wire logic [31:0]                 WB_DAT_I,       // write data
   output logic      [31:0]                 WB_DAT_O,       // read data
   output logic                             WB_ACK_O,       // acknowledge
   input  wire logic                        SUPPLY_OK,      // above threshold
   input  wire logic                        RESET_PIN_N_I,  // pin level
   output logic                             RESET_PIN_N_O,  // pin drive value
   output logic                             RESET_PIN_N_OE, // pin drive on
   input  wire logic                        CLOCK_MISSING,  // detector timeout
   input  wire logic                        CMP_BELOW,      // plus below minus
   input  wire logic                        WDT_EXPIRE,     // watchdog overflow
   input  wire logic                        FLASH_FAULT,    // illegal access
   input  wire logic                        FLASH_WR_REQ,   // erase/write req
   output logic                             FLASH_WR_GRANT, // req let through
   output rsc_pkg::rsc_core_t               CORE_CTRL,      // held in reset
   output rsc_pkg::rsc_exit_t               CORE_EXIT,      // exit actions
   output rsc_pkg::rsc_port_t               PORT_CTRL       // port pin state
);

   // refuse delays the counter cannot hold
   if (POR_DELAY_CYC < 1 || POR_DELAY_CYC >= (1 << rsc_pkg::POR_CNT_W))
      $error("POR_DELAY_CYC out of range");

   // cut on purpose: the range check above keeps the upper bits zero
   localparam logic [rsc_pkg::POR_CNT_W-1:0] DLY_LOAD =
      POR_DELAY_CYC[rsc_pkg::POR_CNT_W-1:0];

   rsc_pkg::rsc_state_t             state_q;     // sequencer state
   rsc_pkg::rsc_state_t             state_d;     // next state
   logic [rsc_pkg::POR_CNT_W-1:0]   dly_q;       // release delay count
   logic [7:0]                      cause_q;     // visible cause flags
   logic [7:0]                      pend_q;      // cause of current reset
   logic [7:0]                      src_vec;     // cause of a new reset
   logic [1:0]                      smon_q;      // monitor enable, select
   logic                            mcd_en_q;    // clock-loss detector on
   logic                            cmp_en_q;    // comparator source on
   logic                            sw_q;        // software request pending
   logic                            drive_q;     // pin pulled low
   logic                            drive_d;     // next pin drive
   logic                            ack_q;       // bus ack
   logic [31:0]                     rdat_q;      // bus read data
   logic                            any_src;     // some source active
   logic                            supply_low;  // monitored supply drop
   logic                            pin_low;     // external pin reset
   logic                            bus_wr;      // write takes effect
   logic [7:0]                      wr_idx;      // addressed word index

   // priority encode the cause of a reset; power classes win
   function automatic logic [7:0] cause_of(input logic sup, input logic pin,
                                           input logic clock_loss_detector, input logic cmp,
                                           input logic wdt, input logic fl,
                                           input logic sw);
      logic [7:0] v;
      v = 8'h00;
      if (sup)
         v[rsc_pkg::BIT_PWR] = 1'b1;
      else if (pin)
         v[rsc_pkg::BIT_PIN] = 1'b1;
      else if (clock_loss_detector)
         v[rsc_pkg::BIT_MCD] = 1'b1;
      else if (cmp)
         v[rsc_pkg::BIT_CMP] = 1'b1;
      else if (wdt)
         v[rsc_pkg::BIT_WDT] = 1'b1;
      else if (fl)
         v[rsc_pkg::BIT_FLASH] = 1'b1;
      else if (sw)
         v[rsc_pkg::BIT_SW] = 1'b1;
      return v;
   endfunction

   // source qualification
   always_comb begin
      // RL9: supply drop counts only when enabled and selected
      supply_low = ~SUPPLY_OK & smon_q[1] & smon_q[0];
      // RL13: our own pull is not an external reset
      pin_low    = ~RESET_PIN_N_I & ~drive_q;
      // RL14: detector gated by its enable
      // RL16: comparator gated by its enable
      // RL18: watchdog expiry
      // RL19: flash fault
      // RL20: software request
      src_vec    = cause_of(supply_low, pin_low, CLOCK_MISSING & mcd_en_q,
                            CMP_BELOW & cmp_en_q, WDT_EXPIRE, FLASH_FAULT,
                            sw_q);
      any_src    = |src_vec;
   end

   // next state of the sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         rsc_pkg::ST_RUN: begin
            if (any_src)
               state_d = rsc_pkg::ST_HOLD;
         end
         // RL6: hold until supply above threshold
         rsc_pkg::ST_POR: begin
            if (SUPPLY_OK)
               state_d = rsc_pkg::ST_DELAY;
         end
         // RL6: release delay, restarted on a new drop
         rsc_pkg::ST_DELAY: begin
            if (!SUPPLY_OK)
               state_d = rsc_pkg::ST_POR;
            else if (dly_q == 1)
               state_d = rsc_pkg::ST_EXIT;
         end
         // RL10: supply reset leaves with no delay
         rsc_pkg::ST_HOLD: begin
            if (!supply_low && !pin_low && !(CLOCK_MISSING & mcd_en_q) &&
                !(CMP_BELOW & cmp_en_q) && !WDT_EXPIRE && !FLASH_FAULT)
               state_d = rsc_pkg::ST_EXIT;
         end
         rsc_pkg::ST_EXIT: begin
            state_d = rsc_pkg::ST_RUN;
         end
         default: state_d = rsc_pkg::ST_POR;
      endcase
   end

   // RL23: all state on the one clock, release on one edge
   always_ff @(posedge CLK) begin
      if (RST)
         state_q <= rsc_pkg::ST_POR;
      else
         state_q <= state_d;
   end

   // release delay counter, loaded as the supply settles
   always_ff @(posedge CLK) begin
      if (RST)
         dly_q <= '0;
      else if (state_q == rsc_pkg::ST_POR)
         dly_q <= DLY_LOAD;
      else if (state_q == rsc_pkg::ST_DELAY && dly_q != 0)
         dly_q <= dly_q - 1'b1;
   end

   // cause held through the reset, captured on entry
   always_ff @(posedge CLK) begin
      if (RST)
         pend_q <= 8'h01 << rsc_pkg::BIT_PWR;  // power flag
      else if (state_q == rsc_pkg::ST_RUN && any_src)
         pend_q <= src_vec;
   end

   // RL7: visible flags cleared by the power-up root, otherwise change only on exit from reset
   // RL13: pin flag appears on exit
   always_ff @(posedge CLK) begin
      if (RST)
         cause_q <= rsc_pkg::CAUSE_RST;
      else if (state_q == rsc_pkg::ST_EXIT)
         cause_q <= pend_q;
   end

   // RL4: pin pulled low only for the power classes
   always_comb begin
      drive_d = 1'b0;
      if (state_d == rsc_pkg::ST_POR || state_d == rsc_pkg::ST_DELAY)
         drive_d = 1'b1;
      else if (state_d == rsc_pkg::ST_HOLD)
         drive_d = (state_q == rsc_pkg::ST_RUN) ? src_vec[rsc_pkg::BIT_PWR]
                                                : pend_q[rsc_pkg::BIT_PWR];
   end

   // pin drive flop, low from the power-up reset on
   always_ff @(posedge CLK) begin
      if (RST)
         drive_q <= 1'b1;
      else
         drive_q <= drive_d;
   end

   // bus writes only land while the core runs
   assign wr_idx = WB_ADR_I[rsc_pkg::WB_ADR_W-1:2];
   assign bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q & WB_SEL_I[0] &
                   (state_q == rsc_pkg::ST_RUN);

   // RL8: power-up enables and selects the monitor
   // RL11: no other reset touches it
   always_ff @(posedge CLK) begin
      if (RST)
         smon_q <= rsc_pkg::SMON_RST;
      else if (bus_wr && wr_idx == rsc_pkg::REG_SMON_IDX)
         smon_q <= {WB_DAT_I[rsc_pkg::BIT_SMON_EN],
                    WB_DAT_I[rsc_pkg::BIT_SMON_SEL]};
   end

   // RL15: clock-loss enable, cleared by any reset
   // RL16: comparator enable, cleared by any reset
   always_ff @(posedge CLK) begin
      if (RST || state_q != rsc_pkg::ST_RUN) begin
         mcd_en_q <= 1'b0;
         cmp_en_q <= 1'b0;
      end else if (bus_wr && wr_idx == rsc_pkg::REG_CAUSE_IDX) begin
         mcd_en_q <= WB_DAT_I[rsc_pkg::BIT_MCD];
         cmp_en_q <= WB_DAT_I[rsc_pkg::BIT_CMP];
      end
   end

   // RL20: software request, consumed on entry to reset
   always_ff @(posedge CLK) begin
      if (RST || state_q == rsc_pkg::ST_HOLD)
         sw_q <= 1'b0;
      else if (bus_wr && wr_idx == rsc_pkg::REG_CAUSE_IDX &&
               WB_DAT_I[rsc_pkg::BIT_SW])
         sw_q <= 1'b1;
   end

   // one-cycle ack, dropped the cycle after it is given
   always_ff @(posedge CLK) begin
      if (RST)
         ack_q <= 1'b0;
      else
         ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
   end

   // RL21: cause read, bit 7 reserved as zero
   // RL22: cause at its fixed index, unmapped reads zero
   always_ff @(posedge CLK) begin
      if (RST)
         rdat_q <= 32'h0000_0000;
      else if (WB_CYC_I && WB_STB_I && !ack_q) begin
         if (wr_idx == rsc_pkg::REG_CAUSE_IDX)
            rdat_q <= {24'h00_0000, 1'b0, cause_q[6:0]};
         else if (wr_idx == rsc_pkg::REG_SMON_IDX)
            rdat_q <= {24'h00_0000, smon_q, 6'h00};
         else
            rdat_q <= 32'h0000_0000;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;

   // RL4: open-drain pin, only ever pulled low
   assign RESET_PIN_N_O  = 1'b0;
   assign RESET_PIN_N_OE = drive_q;

   // RL12: flash erase and write need the monitor on
   assign FLASH_WR_GRANT = FLASH_WR_REQ & smon_q[1];

   // core controls held while not running
   always_comb begin
      // RL1: halt, register init, interrupts and timers off
      CORE_CTRL.halt        = (state_q != rsc_pkg::ST_RUN);
      CORE_CTRL.sfr_init    = (state_q != rsc_pkg::ST_RUN);
      CORE_CTRL.irq_tmr_off = (state_q != rsc_pkg::ST_RUN);
      // RL2: only the stack pointer, data memory kept
      CORE_CTRL.sp_init     = (state_q != rsc_pkg::ST_RUN);
      // RL5: one-cycle exit actions
      CORE_EXIT.pc_clear     = (state_q == rsc_pkg::ST_EXIT);
      CORE_EXIT.wdt_enable   = (state_q == rsc_pkg::ST_EXIT);
      CORE_EXIT.clk_internal = (state_q == rsc_pkg::ST_EXIT);
      CORE_EXIT.fetch_addr   = rsc_pkg::FETCH_START;
      // RL3: latches to ones in open drain, pullups always on
      PORT_CTRL.open_drain  = (state_q != rsc_pkg::ST_RUN);
      PORT_CTRL.weak_pullup = 1'b1;
      PORT_CTRL.latch       = rsc_pkg::PORT_RESET_VAL;
   end

   // checks of the sequencer
   AST_CORE_HALT: assert property (@(posedge CLK) disable iff (RST)  // RL1
      any_src && state_q == rsc_pkg::ST_RUN |=> CORE_CTRL.halt)
      else $error("source did not halt the core");

   AST_PORT_ONES: assert property (@(posedge CLK) disable iff (RST)  // RL3
      CORE_CTRL.halt |-> PORT_CTRL.open_drain && PORT_CTRL.latch == 8'hFF)
      else $error("ports not set in reset");

   AST_NO_PIN_SOFT: assert property (@(posedge CLK) disable iff (RST)  // RL4
      state_q == rsc_pkg::ST_HOLD && !pend_q[rsc_pkg::BIT_PWR]
      |-> !RESET_PIN_N_OE)
      else $error("pin driven for a soft reset");

   AST_EXIT_ACTS: assert property (@(posedge CLK) disable iff (RST)  // RL5
      $fell(CORE_CTRL.halt) |-> $past(CORE_EXIT.pc_clear) &&
      $past(CORE_EXIT.wdt_enable))
      else $error("exit without exit actions");

   AST_POR_DELAY: assert property (@(posedge CLK) disable iff (RST)  // RL6
      $rose(state_q == rsc_pkg::ST_EXIT) && $past(state_q) ==
      rsc_pkg::ST_DELAY |-> $past(dly_q) == 1)
      else $error("power-up release before delay");

   AST_PWR_FLAG: assert property (@(posedge CLK) disable iff (RST)  // RL7
      state_q == rsc_pkg::ST_EXIT |=> cause_q[rsc_pkg::BIT_PWR] ==
      $past(pend_q[rsc_pkg::BIT_PWR]) && $countones(cause_q) == 1)
      else $error("cause flags wrong after exit");

   AST_SUPPLY_DRIVE: assert property (@(posedge CLK) disable iff (RST)  // RL9
      state_q == rsc_pkg::ST_RUN && supply_low
      |=> state_q == rsc_pkg::ST_HOLD && RESET_PIN_N_OE)
      else $error("supply drop not handled");

   AST_SMON_KEEP: assert property (@(posedge CLK) disable iff (RST)  // RL11
      state_q != rsc_pkg::ST_RUN |=> $stable(smon_q))
      else $error("monitor settings changed by reset");

   AST_FLASH_GATE: assert property (@(posedge CLK) disable iff (RST)  // RL12
      FLASH_WR_GRANT |-> smon_q[1] && FLASH_WR_REQ)
      else $error("flash write passed with monitor off");

   AST_MCD_RESET: assert property (@(posedge CLK) disable iff (RST)  // RL14
      state_q == rsc_pkg::ST_RUN && mcd_en_q && CLOCK_MISSING && !supply_low
      && !pin_low |=> pend_q == 8'h04 ##1 state_q != rsc_pkg::ST_RUN)
      else $error("missing clock did not reset");

   AST_SW_RESET: assert property (@(posedge CLK) disable iff (RST)  // RL20
      bus_wr && wr_idx == rsc_pkg::REG_CAUSE_IDX && WB_DAT_I[rsc_pkg::BIT_SW]
      |-> ##[1:2] state_q == rsc_pkg::ST_HOLD)
      else $error("software reset not taken");

   // main scenarios
   COV_POWER_UP: cover property (@(posedge CLK) disable iff (RST)
      state_q == rsc_pkg::ST_DELAY ##1 state_q == rsc_pkg::ST_EXIT);
   COV_SOFT: cover property (@(posedge CLK) disable iff (RST)
      state_q == rsc_pkg::ST_EXIT && pend_q[rsc_pkg::BIT_SW]);
   COV_SUPPLY: cover property (@(posedge CLK) disable iff (RST)
      state_q == rsc_pkg::ST_EXIT && pend_q[rsc_pkg::BIT_PWR]);
   COV_WDT: cover property (@(posedge CLK) disable iff (RST)
      state_q == rsc_pkg::ST_EXIT && pend_q[rsc_pkg::BIT_WDT]);

endmodule // rsc_ctrl

// File: verif/rsc_pin_model.sv
`timescale 1ns/100ps
// far side of the reset pin: external pull-down, pull-up, slow release
module rsc_pin_model (
   input  wire logic       clk,       // system clock
   input  wire logic       pull_low,  // external reset request
   input  wire logic [1:0] rise_cyc,  // cycles the pin lags on release
   input  wire logic       dut_o,     // device drive value
   input  wire logic       dut_oe,    // device pulls the pin
   output logic            pin_n      // resolved pin level
);
   logic [1:0] lag_q = 2'h0;  // release lag still to run

   // a weak pull-up recharges the pin slowly, so release can lag
   always_ff @(posedge clk) begin
      if (pull_low) begin
         lag_q <= rise_cyc;
      end else if (lag_q != 2'h0) begin
         lag_q <= lag_q - 2'h1;
      end
   end

   always_comb begin
      pin_n = 1'h1;  // pull-up sets the idle level
      if (pull_low || lag_q != 2'h0) begin
         pin_n = 1'h0;
      end
      // open drain: the device can only pull low
      if (dut_oe && !dut_o) begin
         pin_n = 1'h0;
      end
   end
endmodule // rsc_pin_model

// File: verif/tb_rsc_ctrl.sv
`timescale 1ns/100ps
module tb_rsc_ctrl;
   localparam int PDLY = 12;  // shortened power-up release delay
   localparam logic [7:0] CA = rsc_pkg::REG_CAUSE_IDX;
   localparam logic [7:0] MO = rsc_pkg::REG_SMON_IDX;
   logic clk, rst, cyc, stb, we, ack;    // clock, reset, bus strobes
   logic [9:0]  adr;                     // bus byte address
   logic [3:0]  sel;                     // byte lanes
   logic [31:0] wdat, rdat;              // bus data
   logic supply_ok, pin_n, pin_o, pin_oe, pull_low;  // supply and pin
   logic clk_miss, cmp_below, wdt_exp, fl_fault, fl_req, fl_grant;
   logic [1:0]  rise;                    // pin release lag
   rsc_pkg::rsc_core_t core_ctrl;        // core controls
   rsc_pkg::rsc_exit_t core_exit;        // exit actions
   rsc_pkg::rsc_port_t port_ctrl;        // port state
   int failures, checks, oe_cnt, exit_cnt, halt_cnt, n, i;
   logic [15:0] rnd;                     // random state
   logic [7:0]  q;                       // read data
   int src[7] = '{rsc_pkg::BIT_PWR, rsc_pkg::BIT_PIN, rsc_pkg::BIT_MCD,
      rsc_pkg::BIT_CMP, rsc_pkg::BIT_WDT, rsc_pkg::BIT_FLASH, rsc_pkg::BIT_SW};

   rsc_ctrl #(.POR_DELAY_CYC(PDLY)) dut_u (.CLK(clk), .RST(rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .SUPPLY_OK(supply_ok), .RESET_PIN_N_I(pin_n), .RESET_PIN_N_O(pin_o),
      .RESET_PIN_N_OE(pin_oe), .CLOCK_MISSING(clk_miss),
      .CMP_BELOW(cmp_below), .WDT_EXPIRE(wdt_exp), .FLASH_FAULT(fl_fault),
      .FLASH_WR_REQ(fl_req), .FLASH_WR_GRANT(fl_grant),
      .CORE_CTRL(core_ctrl), .CORE_EXIT(core_exit), .PORT_CTRL(port_ctrl));
   rsc_pin_model pin_u (.clk(clk), .pull_low(pull_low), .rise_cyc(rise),
      .dut_o(pin_o), .dut_oe(pin_oe), .pin_n(pin_n));

   // free-running 200 MHz clock
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // maximal-length 16-bit shift register
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // cause register after a reset of one kind: exactly that flag
   function automatic logic [31:0] exp_cause(input int k);
      return 32'h1 << k;
   endfunction

   // classic single cycle; waits for ack, only the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] s,
                     output logic [7:0] r);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {idx, 2'h0};
      sel <= s;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      check("bus ack", {31'h0, ack}, 32'h1);
      r = rdat[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask

   // wait for the halt level, bounded
   task automatic wait_halt(input logic v, input int lim, output int k);
      k = 0;
      while (core_ctrl.halt !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      check("halt level", {31'h0, core_ctrl.halt}, {31'h0, v});
   endtask

   // trigger one source and check the recorded cause afterwards
   task automatic run_src(input int k);
      int len, o0, e0;
      logic [7:0] r;
      rnd = lfsr(rnd);
      len = 2 + int'(rnd[2:0]);
      rise <= rnd[4:3];
      if (k == rsc_pkg::BIT_MCD) wb(1'h1, CA, 8'h04, 4'hF, r);
      // comparator output kept quiet while its reset is enabled
      if (k == rsc_pkg::BIT_CMP) wb(1'h1, CA, 8'h20, 4'hF, r);
      o0 = oe_cnt;
      e0 = exit_cnt;
      @(posedge clk);
      case (k)
         rsc_pkg::BIT_PWR:   supply_ok <= 1'h0;
         rsc_pkg::BIT_PIN:   pull_low <= 1'h1;
         rsc_pkg::BIT_MCD:   clk_miss <= 1'h1;
         rsc_pkg::BIT_CMP:   cmp_below <= 1'h1;
         rsc_pkg::BIT_WDT:   wdt_exp <= 1'h1;
         rsc_pkg::BIT_FLASH: fl_fault <= 1'h1;
         default:            wb(1'h1, CA, 8'h10, 4'hF, r);
      endcase
      if (k == rsc_pkg::BIT_SW) wait_halt(1'h1, 10, n);
      else repeat (len) @(posedge clk);
      {supply_ok, pull_low, clk_miss, cmp_below, wdt_exp, fl_fault}
         <= 6'h20;
      wait_halt(1'h0, 60, n);
      if (k == rsc_pkg::BIT_PWR) check("pwr delay", n < PDLY, 32'h1);
      wb(1'h0, CA, 8'h00, 4'hF, r);
      check("cause", 32'(r), exp_cause(k));
      check("pwr flag", 32'(r[1]), 32'(k == rsc_pkg::BIT_PWR));
      check("pin drive", oe_cnt != o0, k == rsc_pkg::BIT_PWR);
      check("exit pulse", exit_cnt != e0, 32'h1);
   endtask

   // every cycle once checks have begun: core controls and port state follow the halt level
   always @(posedge clk) begin
      oe_cnt <= oe_cnt + int'(pin_oe);
      halt_cnt <= halt_cnt + int'(core_ctrl.halt);
      if (&{core_exit.pc_clear, core_exit.wdt_enable, core_exit.clk_internal})
         begin
         exit_cnt <= exit_cnt + 1;
         check("fetch", {16'h0, core_exit.fetch_addr}, 32'h0);
      end
      if (checks > 0) begin
         if (pin_oe) check("pin drive low", {31'h0, pin_o}, 32'h0);
         check("core", {28'h0, core_ctrl}, {28'h0, {4{core_ctrl.halt}}});
         check("port", {22'h0, port_ctrl},
               {22'h0, core_ctrl.halt, 1'h1, 8'hFF});
      end
   end

   // watchdog against a hang
   initial begin
      #(20000 * 5);
      failures++;
      close_out;
   end

   initial begin
      {cyc, stb, we, adr, sel, wdat} = '0;
      {failures, checks, oe_cnt, exit_cnt, halt_cnt} = '0;
      {pull_low, clk_miss, cmp_below, wdt_exp, fl_fault, fl_req} = '0;
      rise = 2'h0;
      supply_ok = 1'h0;
      rnd = 16'h6AAF;
      rst = 1'h1;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      repeat (5) @(posedge clk);
      check("supply wait", {31'h0, core_ctrl.halt & pin_oe}, 32'h1);
      supply_ok <= 1'h1;
      wait_halt(1'h0, 100, n);
      check("por delay", n >= PDLY + 2 && n <= PDLY + 4, 32'h1);
      wb(1'h0, CA, 8'h00, 4'hF, q);
      check("por cause", {24'h0, q}, 32'h02);
      wb(1'h0, MO, 8'h00, 4'hF, q);
      check("por monitor", {24'h0, q}, 32'hC0);
      // sources with their enables off, and a masked software write
      i = halt_cnt;
      {clk_miss, cmp_below} <= 2'h3;
      repeat (4) @(posedge clk);
      {clk_miss, cmp_below} <= 2'h0;
      wb(1'h1, CA, 8'h10, 4'hE, q);
      repeat (4) @(posedge clk);
      check("no reset", halt_cnt, i);
      // read-only and reserved positions keep their value
      wb(1'h1, CA, 8'hCB, 4'hF, q);
      for (n = 0; n < 4; n++) begin
         rnd = lfsr(rnd);
         wb(1'h1, {1'h0, rnd[6:0]}, rnd[15:8], 4'hF, q);
         wb(1'h0, {1'h0, rnd[6:0]}, 8'h00, 4'hF, q);
         check("unmapped", {24'h0, q}, 32'h0);
      end
      wb(1'h0, CA, 8'h00, 4'hF, q);
      check("read only", {24'h0, q}, 32'h02);
      foreach (src[j]) run_src(src[j]);
      // monitor off: flash requests refused, settings survive resets
      wb(1'h1, MO, 8'h00, 4'hF, q);
      fl_req <= 1'h1;
      wdt_exp <= 1'h1;
      wait_halt(1'h1, 10, n);
      wb(1'h1, MO, 8'hC0, 4'hF, q);
      wdt_exp <= 1'h0;
      wait_halt(1'h0, 60, n);
      wb(1'h0, MO, 8'h00, 4'hF, q);
      check("monitor kept", {24'h0, q}, 32'h00);
      check("grant off", {31'h0, fl_grant}, 32'h0);
      wb(1'h0, CA, 8'h00, 4'hF, q);
      check("wdt cause", {24'h0, q}, 32'h08);
      // second power-up restores the monitor
      rst <= 1'h1;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      wait_halt(1'h0, 100, n);
      wb(1'h0, MO, 8'h00, 4'hF, q);
      check("monitor again", {24'h0, q}, 32'hC0);
      check("grant on", {31'h0, fl_grant}, 32'h1);
      close_out;
   end
endmodule // tb_rsc_ctrl
